// ==== cbw_bridge_gen.sv ====
// Complementary bridge waveform generator with half- and full-bridge dead band
//
// The implementer's own choices: the address map and the plain strobed port.
`default_nettype none
module cbw_bridge_gen
   import cbw_pkg::*;
#(
   parameter int DB_W = CBW_DB_W
)
(
   // Clock and reset
   input  wire logic                   core_clk_i,
   input  wire logic                   rst_i,
   // Register port
   input  wire logic [CBW_ADDR_W-1:0]  reg_addr_i,
   input  wire logic [CBW_DATA_W-1:0]  reg_wdata_i,
   input  wire logic                   reg_wr_i,
   input  wire logic                   reg_rd_i,
   output logic      [CBW_DATA_W-1:0]  reg_rdata_o,
   // Modulation sources
   input  wire logic                   pin_input_selection_i,
   input  wire logic                   capture_compare_unit_one_out_i,
   input  wire logic                   capture_compare_unit_two_out_i,
   input  wire logic                   pulse_width_unit_three_out_i,
   input  wire logic                   pulse_width_unit_four_out_i,
   input  wire logic                   comparator_one_out_i,
   input  wire logic                   comparator_two_out_i,
   input  wire logic                   data_signal_modulator_out_i,
   // Timing and power
   input  wire logic                   internal_fast_oscillator_tick_i,
   input  wire logic                   sleep_i,
   input  wire logic                   shutdown_i,
   // Bridge drives
   output logic                        bridge_out_a_o,
   output logic                        bridge_out_b_o,
   output logic                        bridge_out_c_o,
   output logic                        bridge_out_d_o
);

   if (DB_W < 1 || DB_W > CBW_DATA_W)
   begin : g_chk
      $error("DB_W must lie between 1 and the register data width");
   end

   // Software-visible state
   logic                   en_r;
   logic [2:0]             mode_r;
   logic [3:0]             pol_r;
   logic [3:0]             ovr_r;
   logic                   cs_r;
   logic [2:0]             isel_r;
   logic [DB_W-1:0]        dbr_r;
   logic [DB_W-1:0]        dbf_r;
   logic [CBW_DATA_W-1:0]  rdata_r;

   // Generator state
   logic                   in_prev_r;
   logic                   dir_r;
   logic                   dir_nxt;
   logic                   hold_r;
   logic                   hold_nxt;
   logic [3:0]             act_r;
   logic [3:0]             act_nxt;
   logic [3:0]             out_r;
   logic [3:0]             out_nxt;

   cbw_db_if #(.W(DB_W)) rdb_if ();
   cbw_db_if #(.W(DB_W)) fdb_if ();

   // Register decode
   wire wr_con0_w   = reg_wr_i && reg_addr_i == CBW_REG_CON0;
   wire wr_con1_w   = reg_wr_i && reg_addr_i == CBW_REG_CON1;
   wire wr_clkcon_w = reg_wr_i && reg_addr_i == CBW_REG_CLKCON;
   wire wr_ism_w    = reg_wr_i && reg_addr_i == CBW_REG_ISM;
   wire wr_dbr_w    = reg_wr_i && reg_addr_i == CBW_REG_DBR;
   wire wr_dbf_w    = reg_wr_i && reg_addr_i == CBW_REG_DBF;

   wire [CBW_DATA_W-1:0] con0_w = {en_r, 4'h0, mode_r};
   wire [CBW_DATA_W-1:0] con1_w = {ovr_r, pol_r};
   wire [CBW_DATA_W-1:0] stat_w = {out_r, 1'b0, (dir_r != mode_r[CBW_MODE_DIR_BIT]) && cbw_is_full(mode_r),
                                   hold_r, dir_r};

   // Unmapped indexes read as zero
   wire [CBW_DATA_W-1:0] rd_mux_w =
      (reg_addr_i == CBW_REG_CON0)   ? con0_w :
      (reg_addr_i == CBW_REG_CON1)   ? con1_w :
      (reg_addr_i == CBW_REG_CLKCON) ? CBW_DATA_W'(cs_r) :
      (reg_addr_i == CBW_REG_ISM)    ? CBW_DATA_W'(isel_r) :
      (reg_addr_i == CBW_REG_DBR)    ? CBW_DATA_W'(dbr_r) :
      (reg_addr_i == CBW_REG_DBF)    ? CBW_DATA_W'(dbf_r) :
      (reg_addr_i == CBW_REG_STATUS) ? stat_w : '0;

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         en_r   <= 1'b0;
         mode_r <= CBW_MODE_RST;
         pol_r  <= CBW_POL_RST;
         ovr_r  <= CBW_OVR_RST;
         cs_r   <= 1'b0;
         isel_r <= CBW_SRC_PIN;
         dbr_r  <= '0;
         dbf_r  <= '0;
      end
      else
      begin
         if (wr_con0_w)
         begin
            en_r   <= reg_wdata_i[CBW_CON0_EN_BIT];
            mode_r <= reg_wdata_i[2:0];
         end
         if (wr_con1_w)
         begin
            pol_r <= reg_wdata_i[3:0];
            ovr_r <= reg_wdata_i[CBW_CON1_OVR_LSB +: 4];
         end
         if (wr_clkcon_w)
            cs_r <= reg_wdata_i[CBW_CLK_CS_BIT];
         if (wr_ism_w)
            isel_r <= reg_wdata_i[2:0];
         if (wr_dbr_w)
            dbr_r <= reg_wdata_i[DB_W-1:0];
         if (wr_dbf_w)
            dbf_r <= reg_wdata_i[DB_W-1:0];
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         rdata_r <= '0;
      else
         rdata_r <= reg_rd_i ? rd_mux_w : '0;
   end

   wire [7:0] src_w = {data_signal_modulator_out_i, comparator_two_out_i, comparator_one_out_i,
                       pulse_width_unit_four_out_i, pulse_width_unit_three_out_i,
                       capture_compare_unit_two_out_i, capture_compare_unit_one_out_i, pin_input_selection_i};
   wire       sel_in_w = src_w[isel_r];
   wire       rise_w   = sel_in_w && !in_prev_r;
   wire       fall_w   = !sel_in_w && in_prev_r;

   wire       half_w   = en_r && mode_r == CBW_MODE_HALF;
   wire       full_w   = en_r && cbw_is_full(mode_r);
   wire       idle_w   = !half_w && !full_w;
   wire       mdir_w   = mode_r[CBW_MODE_DIR_BIT];

   // system clock stops in sleep, the oscillator does not
   wire       tick_w   = cs_r ? internal_fast_oscillator_tick_i : !sleep_i;

   wire       chg_w    = full_w && rise_w && (mdir_w != dir_r);
   assign dir_nxt = full_w ? (chg_w ? mdir_w : dir_r) : mdir_w;

   // rising counter: half rise or reverse; falling counter: half fall or forward
   wire       rstart_w = half_w ? rise_w : (chg_w && mdir_w);
   wire       fstart_w = half_w ? fall_w : (chg_w && !mdir_w);
   assign rdb_if.start = rstart_w;
   assign rdb_if.abort = idle_w || (half_w && fall_w) || (full_w && fstart_w);
   assign rdb_if.tick  = tick_w;
   assign rdb_if.limit = dbr_r;
   assign fdb_if.start = fstart_w;
   assign fdb_if.abort = idle_w || (half_w && rise_w) || (full_w && rstart_w);
   assign fdb_if.tick  = tick_w;
   assign fdb_if.limit = dbf_r;

   cbw_db_counter #(.W(DB_W)) u_rise_db
   (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .db         (rdb_if.cnt)
   );

   cbw_db_counter #(.W(DB_W)) u_fall_db
   (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .db         (fdb_if.cnt)
   );

   wire db_done_w = rdb_if.done || fdb_if.done;

   // hold new modulated output until dead band ends
   assign hold_nxt = full_w && (chg_w || hold_r) && !db_done_w;

   // half bridge: each output rises a dead band after the other falls
   wire hb_a_w = fall_w ? 1'b0 : (rdb_if.done ? 1'b1 : act_r[0]);
   wire hb_b_w = rise_w ? 1'b0 : (fdb_if.done ? 1'b1 : act_r[1]);

   // static pair from direction, modulated pair gated by hold
   // A and C take no dead band
   // B or D modulates after the hold
   wire fb_mod_w = !hold_nxt && sel_in_w;
   wire [3:0] fb_w = {!dir_nxt && fb_mod_w, dir_nxt, dir_nxt && fb_mod_w, !dir_nxt};

   assign act_nxt = half_w ? {hb_b_w, hb_a_w, hb_b_w, hb_a_w} :
                    full_w ? fb_w : 4'h0;

   assign out_nxt = shutdown_i ? ovr_r : ~(act_nxt ^ pol_r);

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         in_prev_r <= 1'b0;
         dir_r     <= 1'b0;
         hold_r    <= 1'b0;
         act_r     <= 4'h0;
         out_r     <= 4'h0;
      end
      else
      begin
         in_prev_r <= sel_in_w;
         dir_r     <= dir_nxt;
         hold_r    <= hold_nxt;
         act_r     <= act_nxt;
         out_r     <= out_nxt;
      end
   end

   assign reg_rdata_o    = rdata_r;
   assign bridge_out_a_o = out_r[0];
   assign bridge_out_b_o = out_r[1];
   assign bridge_out_c_o = out_r[2];
   assign bridge_out_d_o = out_r[3];

   default clocking cb_main @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   property p_dir_hold;
      full_w && !rise_w |=> $stable(dir_r);
   endproperty
   a_dir_hold: assert property (p_dir_hold) else $error("direction moved without a rising edge");

   property p_swap;
      chg_w |=> act_r[2] == dir_r && act_r[0] == !dir_r && (dir_r ? !act_r[3] : !act_r[1]);
   endproperty
   a_swap: assert property (p_swap) else $error("outputs did not swap on direction change");

   property p_hold_idle;
      hold_r |-> !act_r[1] && !act_r[3];
   endproperty
   a_hold_idle: assert property (p_hold_idle) else $error("modulation during direction dead band");

   property p_fb_no_db;
      full_w && !chg_w && !hold_r |=> !hold_r;
   endproperty
   a_fb_no_db: assert property (p_fb_no_db) else $error("dead band without direction change");

   property p_sys_sleep;
      !cs_r && sleep_i && hold_r && full_w && !chg_w |=> hold_r;
   endproperty
   a_sys_sleep: assert property (p_sys_sleep) else $error("dead band ran on system clock in sleep");

   property p_osc_gate;
      cs_r && !internal_fast_oscillator_tick_i && hold_r && full_w && !chg_w |=> hold_r;
   endproperty
   a_osc_gate: assert property (p_osc_gate) else $error("dead band advanced without oscillator tick");

   property p_hb_zero;
      half_w && rise_w && dbr_r == '0 |=> act_r[0] && !act_r[1];
   endproperty
   a_hb_zero: assert property (p_hb_zero) else $error("zero dead band delayed the edge");

   property p_hb_fall_delay;
      half_w && fall_w && dbf_r != '0 |=> !act_r[1] && !act_r[0];
   endproperty
   a_hb_fall_delay: assert property (p_hb_fall_delay) else $error("inverted output rose without dead band");

   property p_hb_overlap;
      $past(half_w) |-> !(act_r[0] && act_r[1]);
   endproperty
   a_hb_overlap: assert property (p_hb_overlap) else $error("half-bridge drives overlap");

   property p_polarity;
      !shutdown_i |=> out_r == ~(act_r ^ $past(pol_r));
   endproperty
   a_polarity: assert property (p_polarity) else $error("output polarity wrong");

   property p_override;
      shutdown_i |=> out_r == $past(ovr_r);
   endproperty
   a_override: assert property (p_override) else $error("override level wrong in shutdown");

   c_dir_change: cover property (chg_w);
   c_hold_end: cover property (hold_r ##1 !hold_r && full_w);
   c_hb_delayed: cover property (half_w && rdb_if.done && !rise_w);
   c_shutdown: cover property (shutdown_i && full_w);

endmodule
`default_nettype wire

// ==== cbw_db_counter.sv ====
// Dead-band interval counter: counts generator ticks from zero up to a limit
`default_nettype none
module cbw_db_counter
   import cbw_pkg::*;
#(
   parameter int W = CBW_DB_W
)
(
   // Clock and reset
   input  wire logic  core_clk_i,
   input  wire logic  rst_i,
   // Control side
   cbw_db_if.cnt      db
);

   logic [W-1:0]  cnt_r;
   logic [W-1:0]  cnt_nxt;
   logic          busy_r;
   logic          busy_nxt;
   wire  [W-1:0]  cnt_inc_w = W'(cnt_r + 1'b1);
   // Compare with >= so that a limit lowered mid-interval still ends it
   wire           last_w    = cnt_inc_w >= db.limit;
   wire           zero_w    = db.limit == '0;

   assign cnt_nxt  = db.start ? '0 : ((busy_r && db.tick) ? cnt_inc_w : cnt_r);
   assign busy_nxt = db.start ? !zero_w : (!db.abort && busy_r && !(db.tick && last_w));
   assign db.done  = db.start ? zero_w : (!db.abort && busy_r && db.tick && last_w);
   assign db.busy  = busy_r;

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
      end
      else
      begin
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
      end
   end

   property p_cnt_zero;
      @(posedge core_clk_i) disable iff (rst_i)
      db.start && zero_w |-> db.done;
   endproperty
   a_cnt_zero: assert property (p_cnt_zero) else $error("zero dead band did not end at once");

   property p_cnt_from_zero;
      @(posedge core_clk_i) disable iff (rst_i)
      db.start && !zero_w |-> !db.done ##1 (cnt_r == '0 && busy_r);
   endproperty
   a_cnt_from_zero: assert property (p_cnt_from_zero) else $error("interval did not start from zero");

   property p_cnt_end;
      @(posedge core_clk_i) disable iff (rst_i)
      busy_r && !db.start && !db.abort && db.tick && cnt_inc_w == db.limit |-> db.done ##1 !busy_r;
   endproperty
   a_cnt_end: assert property (p_cnt_end) else $error("interval did not end at its limit");

endmodule
`default_nettype wire

// ==== cbw_db_if.sv ====
// Control and status wires of one dead-band counter
`default_nettype none
interface cbw_db_if #(parameter int W = 6);
   logic          start;
   logic          abort;
   logic          tick;
   logic [W-1:0]  limit;
   logic          busy;
   logic          done;

   modport ctl (output start, output abort, output tick, output limit, input busy, input done);
   modport cnt (input start, input abort, input tick, input limit, output busy, output done);
endinterface
`default_nettype wire

// ==== cbw_pkg.sv ====
// Shared constants for the complementary bridge waveform generator
`default_nettype none
package cbw_pkg;

   // Register port geometry
   localparam int          CBW_DATA_W         = 8;
   localparam int          CBW_ADDR_W         = 3;
   localparam int          CBW_DB_W           = 6;

   // Register indexes
   localparam logic [2:0]  CBW_REG_CON0       = 3'h0;
   localparam logic [2:0]  CBW_REG_CON1       = 3'h1;
   localparam logic [2:0]  CBW_REG_CLKCON     = 3'h2;
   localparam logic [2:0]  CBW_REG_ISM        = 3'h3;
   localparam logic [2:0]  CBW_REG_DBR        = 3'h4;
   localparam logic [2:0]  CBW_REG_DBF        = 3'h5;
   localparam logic [2:0]  CBW_REG_STATUS     = 3'h6;

   // Field positions
   localparam int          CBW_CON0_EN_BIT    = 7;
   localparam int          CBW_MODE_DIR_BIT   = 0;
   localparam int          CBW_CON1_OVR_LSB   = 4;
   localparam int          CBW_CLK_CS_BIT     = 0;
   localparam int          CBW_STAT_DIR_BIT   = 0;
   localparam int          CBW_STAT_HOLD_BIT  = 1;
   localparam int          CBW_STAT_PEND_BIT  = 2;
   localparam int          CBW_STAT_OUT_LSB   = 4;

   // Operating modes; bit 0 of a full-bridge code is the direction
   localparam logic [2:0]  CBW_MODE_HALF      = 3'h4;
   localparam logic [2:0]  CBW_MODE_FULL_FWD  = 3'h2;
   localparam logic [2:0]  CBW_MODE_FULL_REV  = 3'h3;

   // Input select codes, also the index into the source vector
   localparam logic [2:0]  CBW_SRC_PIN        = 3'h0;
   localparam logic [2:0]  CBW_SRC_DSM        = 3'h7;

   // Reset values
   localparam logic [2:0]  CBW_MODE_RST       = 3'h0;
   localparam logic [3:0]  CBW_POL_RST        = 4'hf;
   localparam logic [3:0]  CBW_OVR_RST        = 4'h0;

   function automatic logic cbw_is_full(input logic [2:0] mode);
      return (mode == CBW_MODE_FULL_FWD) || (mode == CBW_MODE_FULL_REV);
   endfunction

endpackage
`default_nettype wire

// ==== cbw_switch_model.sv ====
// Power switch driver model that counts simultaneous conduction on a bridge leg
`default_nettype none
module cbw_switch_model
(
   // Sampling
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // Gate drive pins and their active levels
   input  wire logic [3:0]  drive_i,
   input  wire logic [3:0]  pol_i,
   input  wire logic        shutdown_i,
   // Fault count
   output logic      [7:0]  overlap_cnt_o
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [3:0]  on_w;

   // A switch conducts while its pin sits at its active level
   assign on_w = ~(drive_i ^ pol_i);

   // leg overlap watch
   // Override levels are polarity-free and chosen by software, so shutdown is not judged
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         overlap_cnt_o <= 8'h00;
      else if (!shutdown_i && ((on_w[0] && on_w[1]) || (on_w[2] && on_w[3])))
         overlap_cnt_o <= overlap_cnt_o + 8'h01;
   end
endmodule
`default_nettype wire

// ==== complementary_bridge_waveform_gen_bench.sv ====
// Self-checking bench for the complementary bridge waveform generator
`default_nettype none
module complementary_bridge_waveform_gen_bench import cbw_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   logic                   core_clk_i;
   logic                   rst_i;
   logic [CBW_ADDR_W-1:0]  reg_addr;
   logic [CBW_DATA_W-1:0]  reg_wdata;
   logic                   reg_wr;
   logic                   reg_rd;
   logic [CBW_DATA_W-1:0]  reg_rdata;
   logic [7:0]             src;
   logic [2:0]             sel;
   logic [1:0]             osc_cnt;
   logic                   osc_tick;
   logic                   sleep;
   logic                   shutdown;
   logic [3:0]             pol_m;
   logic [3:0]             outs;
   logic [7:0]             overlaps;
   int                     n_errors;
   int                     n_tests;

   cbw_bridge_gen uut (
      .core_clk_i                      (core_clk_i),
      .rst_i                           (rst_i),
      .reg_addr_i                      (reg_addr),
      .reg_wdata_i                     (reg_wdata),
      .reg_wr_i                        (reg_wr),
      .reg_rd_i                        (reg_rd),
      .reg_rdata_o                     (reg_rdata),
      .pin_input_selection_i           (src[0]),
      .capture_compare_unit_one_out_i  (src[1]),
      .capture_compare_unit_two_out_i  (src[2]),
      .pulse_width_unit_three_out_i    (src[3]),
      .pulse_width_unit_four_out_i     (src[4]),
      .comparator_one_out_i            (src[5]),
      .comparator_two_out_i            (src[6]),
      .data_signal_modulator_out_i     (src[7]),
      .internal_fast_oscillator_tick_i (osc_tick),
      .sleep_i                         (sleep),
      .shutdown_i                      (shutdown),
      .bridge_out_a_o                  (outs[0]),
      .bridge_out_b_o                  (outs[1]),
      .bridge_out_c_o                  (outs[2]),
      .bridge_out_d_o                  (outs[3])
   );

   cbw_switch_model sw (
      .core_clk_i    (core_clk_i),
      .rst_i         (rst_i),
      .drive_i       (outs),
      .pol_i         (pol_m),
      .shutdown_i    (shutdown),
      .overlap_cnt_o (overlaps)
   );

   initial
   begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   // Oscillator stand-in: one tick every fourth system cycle
   always @(posedge core_clk_i)
   begin
      osc_cnt <= osc_cnt + 2'h1;
      osc_tick <= (osc_cnt == 2'h3);
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic reg_w(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk_i);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_r(input logic [2:0] a, input logic [7:0] exp, input string what);
      @(posedge core_clk_i);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk_i);
      reg_rd <= 1'b0;
      #1;
      chk(what, exp, reg_rdata);
   endtask

   // Selected input changes; outputs under mask must still show the before value after the delay in edges, then switch on the next edge
   task automatic edge_chk(input logic v, input int dly, input logic [3:0] mask, input logic [3:0] bef,
                           input logic [3:0] aft);
      @(posedge core_clk_i);
      src[sel] <= v;
      repeat (dly) @(posedge core_clk_i);
      #1;
      chk("outputs before edge", {4'h0, bef}, {4'h0, outs & mask});
      @(posedge core_clk_i);
      #1;
      chk("outputs after edge", {4'h0, aft}, {4'h0, outs & mask});
   endtask

   task automatic wait_chk(input int n, input logic [3:0] exp);
      repeat (n) @(posedge core_clk_i);
      #1;
      chk("outputs", {4'h0, exp}, {4'h0, outs});
   endtask

   task automatic wait_for(input logic [3:0] exp, input int lim);
      int i;
      i = 0;
      while (outs !== exp && i < lim)
      begin
         @(posedge core_clk_i);
         #1;
         i++;
      end
      chk("outputs in time", {4'h0, exp}, {4'h0, outs});
   endtask

   task automatic t_reset;
      reg_r(CBW_REG_STATUS, 8'h00, "status at reset");
      reg_r(CBW_REG_CON1, 8'h0f, "control one at reset");
      reg_r(3'h7, 8'h00, "unmapped index");
      $display("test reset done");
   endtask

   task automatic t_half;
      reg_w(CBW_REG_DBR, 8'h03);
      reg_w(CBW_REG_DBF, 8'h02);
      reg_w(CBW_REG_CON0, 8'h84);
      repeat (3) @(posedge core_clk_i);
      edge_chk(1'b1, 3, 4'h5, 4'h0, 4'h5);
      edge_chk(1'b0, 2, 4'ha, 4'h0, 4'ha);
      wait_chk(0, 4'ha);
      edge_chk(1'b1, 3, 4'hf, 4'h0, 4'h5);
      $display("test half bridge done");
   endtask

   task automatic t_select;
      reg_w(CBW_REG_DBR, 8'h00);
      reg_w(CBW_REG_DBF, 8'h00);
      for (int s = 0; s < 8; s++)
      begin
         src <= 8'h00;
         sel = s[2:0];
         reg_w(CBW_REG_ISM, {5'h00, sel});
         repeat (4) @(posedge core_clk_i);
         src <= ~(8'h01 << s);
         repeat (4) @(posedge core_clk_i);
         edge_chk(1'b1, 0, 4'h5, 4'h0, 4'h5);
      end
      src <= 8'h00;
      sel = CBW_SRC_PIN;
      reg_w(CBW_REG_ISM, 8'h00);
      $display("test input select done");
   endtask

   task automatic t_sleep;
      reg_w(CBW_REG_DBR, 8'h02);
      reg_w(CBW_REG_CON0, 8'h00);
      reg_w(CBW_REG_CON0, 8'h84);
      sleep <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      edge_chk(1'b1, 8, 4'h5, 4'h0, 4'h0);
      @(posedge core_clk_i);
      sleep <= 1'b0;
      wait_for(4'h5, 6);
      @(posedge core_clk_i);
      src[0] <= 1'b0;
      reg_w(CBW_REG_CLKCON, 8'h01);
      reg_w(CBW_REG_CON0, 8'h00);
      reg_w(CBW_REG_CON0, 8'h84);
      sleep <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      edge_chk(1'b1, 2, 4'hf, 4'h0, 4'h0);
      wait_for(4'h5, 12);
      sleep <= 1'b0;
      reg_w(CBW_REG_CLKCON, 8'h00);
      $display("test dead band clock done");
   endtask

   task automatic t_full;
      reg_w(CBW_REG_DBR, 8'h03);
      reg_w(CBW_REG_DBF, 8'h02);
      src[0] <= 1'b0;
      reg_w(CBW_REG_CON0, CBW_MODE_FULL_FWD | 8'h80);
      repeat (3) @(posedge core_clk_i);
      wait_chk(0, 4'h1);
      edge_chk(1'b1, 0, 4'hf, 4'h1, 4'h9);
      edge_chk(1'b0, 0, 4'hf, 4'h9, 4'h1);
      // Input held low for the period before the change, keeping the switch pair apart
      reg_w(CBW_REG_CON0, CBW_MODE_FULL_REV | 8'h80);
      reg_r(CBW_REG_STATUS, 8'h14, "status pending");
      wait_chk(3, 4'h1);
      edge_chk(1'b1, 0, 4'hf, 4'h1, 4'h4);
      wait_chk(2, 4'h4);
      wait_chk(1, 4'h6);
      edge_chk(1'b0, 0, 4'hf, 4'h6, 4'h4);
      reg_w(CBW_REG_CON0, CBW_MODE_FULL_FWD | 8'h80);
      edge_chk(1'b1, 0, 4'hf, 4'h4, 4'h1);
      wait_chk(1, 4'h1);
      wait_chk(1, 4'h9);
      $display("test full bridge done");
   endtask

   task automatic t_polarity;
      logic [7:0] val;
      for (int p = 0; p < 2; p++)
      begin
         val = (p == 0) ? 8'h50 : 8'h5f;
         @(posedge core_clk_i);
         shutdown <= 1'b1;
         reg_w(CBW_REG_CON1, val);
         wait_chk(2, 4'h5);
         @(posedge core_clk_i);
         pol_m <= val[3:0];
         shutdown <= 1'b0;
         wait_chk(2, (p == 0) ? 4'h6 : 4'h9);
      end
      $display("test polarity done");
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge core_clk_i);
      n_errors++;
      $display("Error watchdog expected done seen timeout");
      finish_test();
   end

   initial
   begin
      n_errors = 0;
      n_tests = 0;
      rst_i = 1'b1;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      src = 8'h00;
      sel = CBW_SRC_PIN;
      osc_cnt = 2'h0;
      osc_tick = 1'b0;
      sleep = 1'b0;
      shutdown = 1'b0;
      pol_m = CBW_POL_RST;
      repeat (12) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      t_reset();
      t_half();
      t_select();
      t_sleep();
      t_full();
      t_polarity();
      chk("switch overlap", 8'h00, overlaps);
      finish_test();
   end
endmodule
`default_nettype wire
